// >>> inc/rtca_cfg.svh
// Purpose: offsets, field positions, reset values and rates of the alarm and clock-output block
// Assumes: byte-wide registers at consecutive byte addresses on the serial register port
// Notes: definitions only
`ifndef RTCA_CFG_SVH
`define RTCA_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RTCA_OFS_MONTH 8'h07
`define RTCA_OFS_YEAR 8'h08
`define RTCA_OFS_AL_MIN 8'h09
`define RTCA_OFS_AL_HOUR 8'h0a
`define RTCA_OFS_AL_DAY 8'h0b
`define RTCA_OFS_AL_WDAY 8'h0c
`define RTCA_OFS_CLOCK_OUTPUT_PIN 8'h0d

// ----------------------------------------
// field positions
// ----------------------------------------
`define RTCA_CENTURY_BIT 7
`define RTCA_MONTH_MSB 4
`define RTCA_ALOFF_BIT 7
`define RTCA_MIN_MSB 6
`define RTCA_HOUR_MSB 5
`define RTCA_DAY_MSB 5
`define RTCA_WDAY_MSB 2
`define RTCA_OUTEN_BIT 7
`define RTCA_RATE_MSB 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define RTCA_RST_MONTH 8'h01
`define RTCA_RST_YEAR 8'h00
`define RTCA_RST_ALARM 8'h80
`define RTCA_RST_CLOCK_OUTPUT_PIN 8'h80

// ----------------------------------------
// bcd limits and rates
// ----------------------------------------
`define RTCA_YEAR_MAX 8'h99
`define RTCA_MIN_MAX 8'h59
`define RTCA_HOUR_MAX 8'h23
`define RTCA_DAY_MAX 8'h31
`define RTCA_WDAY_MAX 8'h06
`define RTCA_OSC_HZ 32768
`define RTCA_F1024_HZ 1024
`define RTCA_F32_HZ 32
`define RTCA_F1_HZ 1

`endif

// >>> inc/rtca_pkg.sv
// Purpose: types shared by the alarm and clock-output block
// Assumes: nothing
// Notes: numbers live in rtca_cfg.svh
package rtca_pkg;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtca_regreq_type;

  typedef struct packed {
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] weekday;
  } rtca_time_type;

  typedef logic [1:0] rtca_rate_type;

endpackage : rtca_pkg

// >>> rtl/rtca_sync_edge.sv
// Purpose: bring the oscillator level into the clock domain and find its rising edges
// Assumes: input is asynchronous to clock
// Notes: first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module rtca_sync_edge (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // asynchronous level
  input wire logic async_in,
  // synchronised view
  output logic level,
  output logic rise
);
  import rtca_pkg::*;

  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r & ce;

endmodule : rtca_sync_edge
`default_nettype wire

// >>> rtl/rtca_clock_output_pin.sv
// Purpose: divide the oscillator and drive the clock output pin
// Assumes: osc_rise is one cycle per oscillator rising edge
// Notes: divider runs even when the pin is off, so a re-enable resumes in phase
`include "rtca_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rtca_clock_output_pin (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // oscillator view
  input wire logic osc_lvl,
  input wire logic osc_rise,
  // control
  input wire logic enable,
  input wire rtca_pkg::rtca_rate_type rate,
  // pin
  output logic pin_o,
  output logic pin_oe
);
  import rtca_pkg::*;

  localparam int B1024 = $clog2(`RTCA_OSC_HZ / `RTCA_F1024_HZ) - 1;
  localparam int B32 = $clog2(`RTCA_OSC_HZ / `RTCA_F32_HZ) - 1;
  localparam int B1 = $clog2(`RTCA_OSC_HZ / `RTCA_F1_HZ) - 1;

  logic [B1:0] div_r;
  logic sel;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
    end else if (ce && osc_rise) begin
      div_r <= div_r + 1'b1;
    end
  end

  always_comb begin
    unique case (rate)
      2'h0: sel = osc_lvl;
      2'h1: sel = div_r[B1024];
      2'h2: sel = div_r[B32];
      2'h3: sel = div_r[B1];
    endcase
  end

  // pin stays low while released, so a pulled line never sees a stale high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else if (ce) begin
      pin_o <= enable & sel;
      pin_oe <= enable;
    end
  end

endmodule : rtca_clock_output_pin
`default_nettype wire

// >>> rtl/rtca_alarm_clock_output_pin.sv
// Purpose: year/month-century registers, four-field calendar alarm and clock output control
// Assumes: time counters and year tick come from timekeeping logic on the same clock
// Notes: oscillator input is asynchronous and sampled through two flip-flops
`include "rtca_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rtca_alarm_clock_output_pin (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // register port from the serial slave
  input wire rtca_pkg::rtca_regreq_type reg_req,
  output logic [7:0] reg_rdata,
  // timekeeping
  input wire rtca_pkg::rtca_time_type now,
  input wire logic year_tick,
  // flag access from the control/status register
  input wire logic flag_wr,
  input wire logic flag_wdata,
  output logic alarm_match_flag,
  // oscillator and clock output pin
  input wire logic osc_in,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe
);
  import rtca_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction : bcd_ok

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] >= 4'h9) begin
      r[3:0] = 4'h0;
      r[7:4] = v[7:4] + 4'h1;
    end else begin
      r[3:0] = v[3:0] + 4'h1;
    end
    bcd_inc = r;
  endfunction : bcd_inc

  function automatic logic wr_hit(input rtca_regreq_type q, input logic [7:0] ofs);
    wr_hit = q.wr && (q.addr == ofs);
  endfunction : wr_hit

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] year_r;
  logic [`RTCA_MONTH_MSB:0] month_r;
  logic century_r;
  logic [7:0] al_min_r;
  logic [7:0] al_hour_r;
  logic [7:0] al_day_r;
  logic [7:0] al_wday_r;
  logic clk_en_r;
  rtca_rate_type rate_r;
  logic [7:0] rdata_nxt;
  logic year_wrap;

  assign year_wrap = year_tick && (year_r == `RTCA_YEAR_MAX);

  // software write wins over a tick in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      year_r <= `RTCA_RST_YEAR;
    end else if (ce) begin
      if (wr_hit(reg_req, `RTCA_OFS_YEAR)) begin
        year_r <= reg_req.wdata;
      end else if (year_wrap) begin
        year_r <= 8'h00;
      end else if (year_tick) begin
        year_r <= bcd_inc(year_r);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      month_r <= 5'(`RTCA_RST_MONTH);
      century_r <= 1'b0;
    end else if (ce) begin
      if (wr_hit(reg_req, `RTCA_OFS_MONTH)) begin
        month_r <= reg_req.wdata[`RTCA_MONTH_MSB:0];
        century_r <= reg_req.wdata[`RTCA_CENTURY_BIT];
      end else if (year_wrap && !wr_hit(reg_req, `RTCA_OFS_YEAR)) begin
        century_r <= ~century_r;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      al_min_r <= `RTCA_RST_ALARM;
      al_hour_r <= `RTCA_RST_ALARM;
      al_day_r <= `RTCA_RST_ALARM;
      al_wday_r <= `RTCA_RST_ALARM;
    end else if (ce) begin
      if (wr_hit(reg_req, `RTCA_OFS_AL_MIN)) begin
        al_min_r <= {reg_req.wdata[`RTCA_ALOFF_BIT], reg_req.wdata[`RTCA_MIN_MSB:0]};
      end
      if (wr_hit(reg_req, `RTCA_OFS_AL_HOUR)) begin
        al_hour_r <= {reg_req.wdata[`RTCA_ALOFF_BIT], 1'b0,
                      reg_req.wdata[`RTCA_HOUR_MSB:0]};
      end
      if (wr_hit(reg_req, `RTCA_OFS_AL_DAY)) begin
        al_day_r <= {reg_req.wdata[`RTCA_ALOFF_BIT], 1'b0,
                     reg_req.wdata[`RTCA_DAY_MSB:0]};
      end
      if (wr_hit(reg_req, `RTCA_OFS_AL_WDAY)) begin
        al_wday_r <= {reg_req.wdata[`RTCA_ALOFF_BIT], 4'h0,
                      reg_req.wdata[`RTCA_WDAY_MSB:0]};
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clk_en_r <= 1'(`RTCA_RST_CLOCK_OUTPUT_PIN >> `RTCA_OUTEN_BIT);
      rate_r <= rtca_rate_type'(`RTCA_RST_CLOCK_OUTPUT_PIN);
    end else if (ce && wr_hit(reg_req, `RTCA_OFS_CLOCK_OUTPUT_PIN)) begin
      clk_en_r <= reg_req.wdata[`RTCA_OUTEN_BIT];
      rate_r <= reg_req.wdata[`RTCA_RATE_MSB:0];
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_comb begin
    unique case (reg_req.addr)
      `RTCA_OFS_MONTH: rdata_nxt = {century_r, 2'h0, month_r};
      `RTCA_OFS_YEAR: rdata_nxt = year_r;
      `RTCA_OFS_AL_MIN: rdata_nxt = al_min_r;
      `RTCA_OFS_AL_HOUR: rdata_nxt = al_hour_r;
      `RTCA_OFS_AL_DAY: rdata_nxt = al_day_r;
      `RTCA_OFS_AL_WDAY: rdata_nxt = al_wday_r;
      `RTCA_OFS_CLOCK_OUTPUT_PIN: rdata_nxt = {clk_en_r, 5'h00, rate_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_req.rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // alarm comparison
  // ----------------------------------------
  logic [3:0] act;
  logic [3:0] hit;
  logic cmp_match;
  logic match_prev_r;

  // an enabled field with an out-of-range value takes no part
  always_comb begin
    act[0] = !al_min_r[`RTCA_ALOFF_BIT] &&
             bcd_ok({1'b0, al_min_r[6:0]}, 8'h00, `RTCA_MIN_MAX);
    act[1] = !al_hour_r[`RTCA_ALOFF_BIT] &&
             bcd_ok({2'h0, al_hour_r[5:0]}, 8'h00, `RTCA_HOUR_MAX);
    act[2] = !al_day_r[`RTCA_ALOFF_BIT] &&
             bcd_ok({2'h0, al_day_r[5:0]}, 8'h01, `RTCA_DAY_MAX);
    act[3] = !al_wday_r[`RTCA_ALOFF_BIT] &&
             bcd_ok({5'h00, al_wday_r[2:0]}, 8'h00, `RTCA_WDAY_MAX);
    hit[0] = al_min_r[6:0] == now.minute[6:0];
    hit[1] = al_hour_r[5:0] == now.hour[5:0];
    hit[2] = al_day_r[5:0] == now.day[5:0];
    hit[3] = al_wday_r[2:0] == now.weekday[2:0];
    cmp_match = (|act) && ((hit | ~act) == 4'hf);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      match_prev_r <= 1'b0;
    end else if (ce) begin
      match_prev_r <= cmp_match;
    end
  end

  // a set in the clearing cycle wins, so no match is lost
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      alarm_match_flag <= 1'b0;
    end else if (ce) begin
      if (cmp_match && !match_prev_r) begin
        alarm_match_flag <= 1'b1;
      end else if (flag_wr && !flag_wdata) begin
        alarm_match_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // clock output
  // ----------------------------------------
  logic osc_lvl;
  logic osc_rise;

  rtca_sync_edge u_osc_sync (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .async_in(osc_in),
    .level(osc_lvl),
    .rise(osc_rise)
  );

  rtca_clock_output_pin u_clock_output_pin (
    .clock(clock),
    .nrst(nrst),
    .ce(ce),
    .osc_lvl(osc_lvl),
    .osc_rise(osc_rise),
    .enable(clk_en_r),
    .rate(rate_r),
    .pin_o(clock_output_pin_o),
    .pin_oe(clock_output_pin_oe)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_fresh_match;
    ce && cmp_match && !match_prev_r;
  endsequence

  sequence s_year_wrap;
    ce && year_wrap && !reg_req.wr;
  endsequence

  a_flag_sets: assert property (s_fresh_match |=> alarm_match_flag)
    else $error("flag not set on fresh match");

  a_flag_holds: assert property (
    alarm_match_flag && !(ce && flag_wr && !flag_wdata) |=> alarm_match_flag)
    else $error("flag dropped without software clear");

  a_flag_clear: assert property (
    ce && flag_wr && !flag_wdata && !(cmp_match && !match_prev_r) |=> !alarm_match_flag)
    else $error("flag not cleared by zero write");

  a_no_relatch: assert property (
    !alarm_match_flag && ce && match_prev_r && !flag_wr |=> !alarm_match_flag)
    else $error("flag set by persisting match");

  a_all_off: assert property (
    al_min_r[7] && al_hour_r[7] && al_day_r[7] && al_wday_r[7] |-> !cmp_match)
    else $error("disabled alarms produced a match");

  a_field_ignored: assert property (
    al_hour_r[`RTCA_ALOFF_BIT] && act[0] && !act[2] && !act[3] |-> cmp_match == hit[0])
    else $error("disabled hour field changed the match");

  a_year_wraps: assert property (
    s_year_wrap |=> (year_r == 8'h00) && (century_r != $past(century_r)))
    else $error("year wrap did not toggle century");

  a_century_hold: assert property (
    !(ce && year_wrap) && !(ce && wr_hit(reg_req, `RTCA_OFS_MONTH)) |=> $stable(century_r))
    else $error("century changed without a wrap or write");

  a_year_digit: assert property (
    ce && year_tick && !reg_req.wr && year_r[3:0] != 4'h9 |=>
    year_r[3:0] == $past(year_r[3:0]) + 4'h1 && year_r[7:4] == $past(year_r[7:4]))
    else $error("year units digit did not step");

  a_min_layout: assert property (
    ce && wr_hit(reg_req, `RTCA_OFS_AL_MIN) |=> al_min_r == $past(reg_req.wdata))
    else $error("minute alarm not stored whole");

  a_hour_layout: assert property (
    ce && reg_req.wr && reg_req.addr == `RTCA_OFS_AL_HOUR ##1
    ce && reg_req.rd && reg_req.addr == `RTCA_OFS_AL_HOUR && !reg_req.wr
    |=> reg_rdata == {$past(reg_req.wdata, 2) & 8'hbf})
    else $error("hour alarm readback wrong");

  a_day_layout: assert property (
    ce && wr_hit(reg_req, `RTCA_OFS_AL_DAY) |=> al_day_r[6] == 1'b0)
    else $error("day alarm reserved bit stored");

  a_wday_layout: assert property (
    ce && wr_hit(reg_req, `RTCA_OFS_AL_WDAY) |=> al_wday_r[6:3] == 4'h0)
    else $error("weekday alarm reserved bits stored");

  a_month_mask: assert property (
    ce && reg_req.rd && reg_req.addr == `RTCA_OFS_MONTH |=> reg_rdata[6:5] == 2'h0)
    else $error("month reserved bits not zero");

  a_pin_off: assert property (
    ce && !clk_en_r ##1 ce && !clk_en_r |-> !clock_output_pin_oe && !clock_output_pin_o)
    else $error("clock output driven while disabled");

  a_pin_follow: assert property (
    ce |=> clock_output_pin_oe == $past(clk_en_r))
    else $error("pin enable does not follow control");

  a_pin_on: assert property ($rose(clk_en_r) && ce |=> clock_output_pin_oe)
    else $error("clock output not driven when enabled");

  a_enable_store: assert property (
    ce && wr_hit(reg_req, `RTCA_OFS_CLOCK_OUTPUT_PIN) |=>
    clk_en_r == $past(reg_req.wdata[`RTCA_OUTEN_BIT]))
    else $error("output enable not stored");

  a_rate_store: assert property (
    ce && wr_hit(reg_req, `RTCA_OFS_CLOCK_OUTPUT_PIN) |=>
    rate_r == $past(reg_req.wdata[`RTCA_RATE_MSB:0]))
    else $error("rate select not stored");

  a_fast_rate: assert property (
    ce && clk_en_r && rate_r == 2'h0 |=> clock_output_pin_o == $past(osc_lvl))
    else $error("full-rate output does not follow oscillator");

endmodule : rtca_alarm_clock_output_pin
`default_nettype wire

// >>> bench/rtca_osc_model.sv
// Purpose: free-running crystal oscillator feeding the clock output path
// Assumes: the crystal runs whatever the register traffic does
// Notes: phase offset keeps it unrelated to the system clock
`timescale 1ns/1ps
`default_nettype none
module rtca_osc_model #(
  parameter int HALF_NS = 40
) (
  // oscillator
  output logic osc
);
  initial begin
    osc = 1'b0;
    #3;
    forever #(HALF_NS) osc = ~osc;
  end
endmodule : rtca_osc_model
`default_nettype wire

// >>> bench/tb_top.sv
// Purpose: register, alarm flag and clock output tests
// Assumes: ce held high except where a freeze is tried
// Notes: inputs change 1 ns after the rising edge
`include "rtca_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  $display("[ERR] %s exp %h got %h", nm, exp, got); fail_count++; end end
module tb_top;
  import rtca_pkg::*;
  logic clock, nrst, ce, year_tick, flag_wr, flag_wdata, osc, flag, pin_o, pin_oe;
  logic [7:0] rdata;
  rtca_regreq_type req;
  rtca_time_type now;
  int fail_count, num_checks, cyc, cnt, exp_c;
  int span[4] = '{800, 2560, 16384, 16384};
  int fr[4] = '{`RTCA_OSC_HZ, `RTCA_F1024_HZ, `RTCA_F32_HZ, `RTCA_F1_HZ};
  logic [7:0] wd[7] = '{8'hff, 8'h99, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] rst_v[7] = '{8'h01, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80};
  logic [7:0] msk_v[7] = '{8'h9f, 8'h99, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h83};

  rtca_osc_model rtca_osc_model_i (.osc(osc));
  rtca_alarm_clock_output_pin rtca_alarm_clock_output_pin_i (.clock(clock), .nrst(nrst), .ce(ce),
    .reg_req(req), .reg_rdata(rdata), .now(now), .year_tick(year_tick),
    .flag_wr(flag_wr), .flag_wdata(flag_wdata), .alarm_match_flag(flag),
    .osc_in(osc), .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe));

  // ----------------------------------------
  // clock, timeout, tasks
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // the two slowest rates dominate the run length, about 36k cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc_wait

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    cyc_wait(1);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    req.rd = 1'b1;
    req.addr = a;
    cyc_wait(1);
    req.rd = 1'b0;
    cyc_wait(1);
    `CHK("reg_rdata", e, rdata)
  endtask : rd_chk

  task automatic flag_clear(input logic v);
    flag_wr = 1'b1;
    flag_wdata = v;
    cyc_wait(1);
    flag_wr = 1'b0;
    cyc_wait(2);
  endtask : flag_clear

  task automatic tick();
    year_tick = 1'b1;
    cyc_wait(1);
    year_tick = 1'b0;
  endtask : tick

  task automatic count_rises(input int n, output int c);
    logic last;
    c = 0;
    last = pin_o;
    repeat (n) begin
      cyc_wait(1);
      if (pin_o === 1'b1 && last === 1'b0) c++;
      last = pin_o;
    end
  endtask : count_rises

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    req = '0;
    now = '0;
    year_tick = 1'b0;
    flag_wr = 1'b0;
    flag_wdata = 1'b0;
    repeat (5) @(posedge clock);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(`RTCA_OFS_MONTH + 8'(i), rst_v[i]);
    // an idle edge between writes keeps the strobe from being lowered and raised at once
    for (int i = 0; i < 7; i++) begin
      wr(`RTCA_OFS_MONTH + 8'(i), wd[i]);
      cyc_wait(1);
    end
    for (int i = 0; i < 7; i++) rd_chk(`RTCA_OFS_MONTH + 8'(i), msk_v[i]);
    // write then read at once, back to back
    wr(`RTCA_OFS_AL_HOUR, 8'hff);
    rd_chk(`RTCA_OFS_AL_HOUR, 8'hbf);
    wr(8'h0e, 8'h55);
    rd_chk(8'h0e, 8'h00);
    // century wrap, then a plain tick leaves it alone
    wr(`RTCA_OFS_MONTH, 8'h12);
    rd_chk(`RTCA_OFS_MONTH, 8'h12);
    tick();
    rd_chk(`RTCA_OFS_YEAR, 8'h00);
    rd_chk(`RTCA_OFS_MONTH, 8'h92);
    tick();
    rd_chk(`RTCA_OFS_YEAR, 8'h01);
    rd_chk(`RTCA_OFS_MONTH, 8'h92);
    ce = 1'b0;
    wr(`RTCA_OFS_YEAR, 8'h55);
    ce = 1'b1;
    rd_chk(`RTCA_OFS_YEAR, 8'h01);
    // alarm: minute enabled, hour disabled and mismatching
    now = '{minute: 8'h29, hour: 8'h10, day: 8'h05, weekday: 8'h02};
    wr(`RTCA_OFS_AL_MIN, 8'h30);
    cyc_wait(1);
    wr(`RTCA_OFS_AL_HOUR, 8'h85);
    cyc_wait(3);
    `CHK("flag", 1'b0, flag)
    now.minute = 8'h30;
    cyc_wait(3);
    `CHK("flag", 1'b1, flag)
    now.minute = 8'h31;
    cyc_wait(3);
    `CHK("flag", 1'b1, flag)
    flag_clear(1'b1);
    `CHK("flag", 1'b1, flag)
    flag_clear(1'b0);
    `CHK("flag", 1'b0, flag)
    now.minute = 8'h30;
    cyc_wait(3);
    `CHK("flag", 1'b1, flag)
    flag_clear(1'b0);
    cyc_wait(3);
    `CHK("flag", 1'b0, flag)
    wr(`RTCA_OFS_AL_HOUR, 8'h05);
    now.minute = 8'h31;
    cyc_wait(2);
    now.minute = 8'h30;
    cyc_wait(3);
    `CHK("flag", 1'b0, flag)
    // all four fields enabled; the hour write completes the match
    wr(`RTCA_OFS_AL_DAY, 8'h05);
    cyc_wait(1);
    wr(`RTCA_OFS_AL_WDAY, 8'h02);
    cyc_wait(1);
    wr(`RTCA_OFS_AL_HOUR, 8'h10);
    cyc_wait(3);
    `CHK("flag", 1'b1, flag)
    // clock output off, then every rate
    wr(`RTCA_OFS_CLOCK_OUTPUT_PIN, 8'h00);
    cyc_wait(3);
    `CHK("pin_oe", 1'b0, pin_oe)
    `CHK("pin_o", 1'b0, pin_o)
    for (int r = 0; r < 4; r++) begin
      wr(`RTCA_OFS_CLOCK_OUTPUT_PIN, 8'h80 | 8'(r));
      cyc_wait(8);
      `CHK("pin_oe", 1'b1, pin_oe)
      count_rises(span[r], cnt);
      exp_c = span[r] / (8 * (`RTCA_OSC_HZ / fr[r]));
      `CHK("rises", 1'b1, cnt >= exp_c - 1 && cnt <= exp_c + 1)
    end
    conclude();
  end
endmodule : tb_top
`default_nettype wire
